// file: ubg_map.vh
// Register map, field positions, reset values and constants of the baud-rate generator
`ifndef UBG_MAP_VH
`define UBG_MAP_VH

// Register offsets
`define UBG_ADDR_W 4
`define UBG_OFF_PRESCALE 4'h1
`define UBG_OFF_SAMPLING 4'h2
`define UBG_OFF_CLKSEL 4'h3
`define UBG_OFF_DIV_LOW 4'h4
`define UBG_OFF_DIV_HIGH 4'h5
`define UBG_OFF_FEATURE 4'h6
`define UBG_OFF_MODEM_CTRL 4'h7
`define UBG_OFF_STATUS 4'h8

// Field positions
`define UBG_PRE_INT_HI 7
`define UBG_PRE_INT_LO 3
`define UBG_PRE_FRAC_HI 2
`define UBG_PRE_FRAC_LO 0
`define UBG_SAMP_HI 3
`define UBG_ENH_BIT 4
`define UBG_PRE_EN_BIT 7
`define UBG_CKS_TX_ISO 7
`define UBG_CKS_TX_EXT 6
`define UBG_CKS_DTR_NX 5
`define UBG_CKS_DTR_1X 4
`define UBG_CKS_RX_ISO 3
`define UBG_CKS_RX_EXT 2

// Reset values
`define UBG_RST_PRESCALE 8'h08
`define UBG_RST_SAMPLING 4'h0
`define UBG_RST_BYTE 8'h00
`define UBG_RST_DIV_LOW 8'h01

// Arithmetic constants
`define UBG_SAMP_MIN 4'h4
`define UBG_SAMP_DEFAULT 5'h10
`define UBG_EIGHTHS_ONE 9'h008
`define UBG_PRE_INT_ONE 5'h01
`define UBG_SAMP_HIGH_ZERO 4'h0
`define UBG_STATUS_PAD 4'h0

`endif

// file: ubg_baud_gen.v
// Baud-rate generator: prescaler, divisor, oversampling count and isochronous 1x clocking
`timescale 1ns/1ps
`include "ubg_map.vh"

module ubg_baud_gen (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Register port
	input wire [`UBG_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// External bit clock pins
	input wire ring_indicate_pin,
	input wire data_set_ready_pin,
	// Normal terminal ready level from the rest of the UART
	input wire dtr_normal,
	// Timing enables to transmitter and receiver
	output reg nx_tick,
	output reg tx_sample_tick,
	output reg tx_bit_tick,
	output reg rx_sample_tick,
	output reg tx_iso,
	output reg rx_iso,
	// Terminal ready pin
	output reg data_terminal_ready_pin,
	output reg dtr_clock_out
);

	reg [7:0] clock_prescale_factor;
	reg [3:0] sampling_cycles_per_bit;
	reg [7:0] clock_select_register;
	reg [7:0] divisor_low_byte;
	reg [7:0] divisor_high_byte;
	reg enhanced_mode_bit;
	reg prescaler_enable_bit;

	reg [8:0] pre_acc;
	reg [8:0] next_pre_acc;
	reg pre_tick;
	reg next_pre_tick;
	reg [15:0] div_cnt;
	reg nx_level;
	reg [4:0] samp_cnt;
	reg bit_level;

	reg ri_s1, ri_s2, ri_s3, ri_state;
	reg dsr_s1, dsr_s2, dsr_s3, dsr_state;
	wire ri_rise;
	wire dsr_rise;

	wire enh_on;
	wire pre_on;
	wire [8:0] pre_eighths;
	wire [15:0] divisor;
	wire [4:0] samp_count;
	wire local_bit_tick;
	wire tx_ext_tick;
	wire rx_ext_tick;

	// Sampling count from the 4-bit field
	function [4:0] ubg_samples;
		input [3:0] field;
		begin
			if (field < `UBG_SAMP_MIN) begin
				ubg_samples = `UBG_SAMP_DEFAULT;
			end else begin
				ubg_samples = {1'b0, field};
			end
		end
	endfunction

	// Prescale factor in eighths, integer zero forced to one
	function [8:0] ubg_eighths;
		input [7:0] factor;
		reg [4:0] int_part;
		begin
			int_part = factor[`UBG_PRE_INT_HI:`UBG_PRE_INT_LO];
			if (int_part == 5'h00) begin
				int_part = `UBG_PRE_INT_ONE;
			end
			ubg_eighths = {1'b0, int_part, factor[`UBG_PRE_FRAC_HI:`UBG_PRE_FRAC_LO]};
		end
	endfunction

	// Enhanced controls only count while the enhanced bit is one
	assign enh_on = enhanced_mode_bit;
	assign pre_on = prescaler_enable_bit & enh_on;
	assign pre_eighths = ubg_eighths(clock_prescale_factor);
	// Divisor zero behaves as one
	assign divisor = {divisor_high_byte, divisor_low_byte};
	assign samp_count = ubg_samples(sampling_cycles_per_bit);

	// Register writes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clock_prescale_factor <= `UBG_RST_PRESCALE;
			sampling_cycles_per_bit <= `UBG_RST_SAMPLING;
			clock_select_register <= `UBG_RST_BYTE;
			divisor_low_byte <= `UBG_RST_DIV_LOW;
			divisor_high_byte <= `UBG_RST_BYTE;
			enhanced_mode_bit <= 1'b0;
			prescaler_enable_bit <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				`UBG_OFF_PRESCALE: begin
					clock_prescale_factor <= reg_wdata;
				end
				`UBG_OFF_SAMPLING: begin
					// Upper bits dropped, so 0x10 and 0x11 land on 16x
					sampling_cycles_per_bit <= reg_wdata[`UBG_SAMP_HI:0];
				end
				`UBG_OFF_CLKSEL: begin
					clock_select_register <= reg_wdata;
				end
				`UBG_OFF_DIV_LOW: begin
					divisor_low_byte <= reg_wdata;
				end
				`UBG_OFF_DIV_HIGH: begin
					divisor_high_byte <= reg_wdata;
				end
				`UBG_OFF_FEATURE: begin
					enhanced_mode_bit <= reg_wdata[`UBG_ENH_BIT];
				end
				`UBG_OFF_MODEM_CTRL: begin
					if (enh_on) begin
						prescaler_enable_bit <= reg_wdata[`UBG_PRE_EN_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, data one cycle after the strobe
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `UBG_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`UBG_OFF_PRESCALE: begin
					reg_rdata <= clock_prescale_factor;
				end
				`UBG_OFF_SAMPLING: begin
					reg_rdata <= {`UBG_SAMP_HIGH_ZERO, sampling_cycles_per_bit};
				end
				`UBG_OFF_CLKSEL: begin
					reg_rdata <= clock_select_register;
				end
				`UBG_OFF_DIV_LOW: begin
					reg_rdata <= divisor_low_byte;
				end
				`UBG_OFF_DIV_HIGH: begin
					reg_rdata <= divisor_high_byte;
				end
				`UBG_OFF_FEATURE: begin
					reg_rdata <= {3'h0, enhanced_mode_bit, 4'h0};
				end
				`UBG_OFF_MODEM_CTRL: begin
					reg_rdata <= {prescaler_enable_bit, 7'h00};
				end
				`UBG_OFF_STATUS: begin
					reg_rdata <= {tx_iso, rx_iso, ri_state, dsr_state, `UBG_STATUS_PAD};
				end
				default: begin
					reg_rdata <= `UBG_RST_BYTE;
				end
			endcase
		end else begin
			reg_rdata <= `UBG_RST_BYTE;
		end
	end

	// Fractional prescaler: step eight per clock, emit when the factor is reached
	always @* begin
		next_pre_acc = pre_acc + `UBG_EIGHTHS_ONE;
		next_pre_tick = 1'b0;
		if (!pre_on) begin
			next_pre_acc = 9'h000;
			next_pre_tick = 1'b1;
		end else if (next_pre_acc >= pre_eighths) begin
			next_pre_acc = next_pre_acc - pre_eighths;
			next_pre_tick = 1'b1;
			// A factor lowered mid-count leaves a stale large remainder that would
			// tick every cycle; keep only the fractional phase so the rate is right at once
			if (next_pre_acc >= `UBG_EIGHTHS_ONE) begin
				next_pre_acc = {6'h00, next_pre_acc[2:0]};
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_acc <= 9'h000;
			pre_tick <= 1'b0;
		end else begin
			pre_acc <= next_pre_acc;
			pre_tick <= next_pre_tick;
		end
	end

	// Divisor counter; nx_tick is one cycle per divided period
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= 16'h0000;
			nx_tick <= 1'b0;
			nx_level <= 1'b0;
		end else begin
			nx_tick <= 1'b0;
			if (pre_tick) begin
				if (div_cnt + 16'h0001 >= divisor) begin
					div_cnt <= 16'h0000;
					nx_tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 16'h0001;
				end
			end
			// Square-ish Nx level for the terminal ready pin
			nx_level <= (div_cnt < {1'b0, divisor[15:1]});
		end
	end

	// Sampling counter: one local bit per sample_count oversampling ticks
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			samp_cnt <= 5'h00;
			bit_level <= 1'b0;
		end else begin
			if (nx_tick) begin
				if (samp_cnt + 5'h01 >= samp_count) begin
					samp_cnt <= 5'h00;
				end else begin
					samp_cnt <= samp_cnt + 5'h01;
				end
			end
			bit_level <= (samp_cnt < {1'b0, samp_count[4:1]});
		end
	end

	assign local_bit_tick = nx_tick && (samp_cnt + 5'h01 >= samp_count);

	// Pin synchronisers; a change counts once stages two and three agree
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ri_s1 <= 1'b0;
			ri_s2 <= 1'b0;
			ri_s3 <= 1'b0;
			ri_state <= 1'b0;
			dsr_s1 <= 1'b0;
			dsr_s2 <= 1'b0;
			dsr_s3 <= 1'b0;
			dsr_state <= 1'b0;
		end else begin
			ri_s1 <= ring_indicate_pin;
			ri_s2 <= ri_s1;
			ri_s3 <= ri_s2;
			dsr_s1 <= data_set_ready_pin;
			dsr_s2 <= dsr_s1;
			dsr_s3 <= dsr_s2;
			if (ri_s2 == ri_s3) begin
				ri_state <= ri_s3;
			end
			if (dsr_s2 == dsr_s3) begin
				dsr_state <= dsr_s3;
			end
		end
	end

	assign ri_rise = (ri_s2 == ri_s3) && ri_s3 && !ri_state;
	assign dsr_rise = (dsr_s2 == dsr_s3) && dsr_s3 && !dsr_state;
	assign tx_ext_tick = clock_select_register[`UBG_CKS_TX_EXT] ? ri_rise : local_bit_tick;
	assign rx_ext_tick = clock_select_register[`UBG_CKS_RX_EXT] ? dsr_rise : local_bit_tick;

	// Tick routing: in 1x mode every tick is one bit; sampling count is unused only when the external pin clock is selected
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_iso <= 1'b0;
			rx_iso <= 1'b0;
			tx_sample_tick <= 1'b0;
			tx_bit_tick <= 1'b0;
			rx_sample_tick <= 1'b0;
		end else begin
			tx_iso <= clock_select_register[`UBG_CKS_TX_ISO];
			rx_iso <= clock_select_register[`UBG_CKS_RX_ISO];
			if (clock_select_register[`UBG_CKS_TX_ISO]) begin
				tx_sample_tick <= tx_ext_tick;
				tx_bit_tick <= tx_ext_tick;
			end else begin
				tx_sample_tick <= nx_tick;
				tx_bit_tick <= local_bit_tick;
			end
			if (clock_select_register[`UBG_CKS_RX_ISO]) begin
				rx_sample_tick <= rx_ext_tick;
			end else begin
				rx_sample_tick <= nx_tick;
			end
		end
	end

	// Terminal ready pin: Nx clock wins over 1x clock, else normal level
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_terminal_ready_pin <= 1'b1;
			dtr_clock_out <= 1'b0;
		end else begin
			dtr_clock_out <= clock_select_register[`UBG_CKS_DTR_NX] |
				clock_select_register[`UBG_CKS_DTR_1X];
			if (clock_select_register[`UBG_CKS_DTR_NX]) begin
				data_terminal_ready_pin <= nx_level;
			end else if (clock_select_register[`UBG_CKS_DTR_1X]) begin
				data_terminal_ready_pin <= bit_level;
			end else begin
				data_terminal_ready_pin <= dtr_normal;
			end
		end
	end

endmodule // ubg_baud_gen

// file: ubg_baud_gen_sva.sv
// Port assertions for the baud-rate generator
`timescale 1ns/1ps
`include "ubg_map.vh"
module ubg_baud_gen_sva (
	// Clock, reset and register port
	input wire clk,
	input wire rst_b,
	input wire [`UBG_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Pins and timing outputs
	input wire ring_indicate_pin,
	input wire data_set_ready_pin,
	input wire dtr_normal,
	input wire nx_tick,
	input wire tx_sample_tick,
	input wire tx_bit_tick,
	input wire rx_sample_tick,
	input wire tx_iso,
	input wire rx_iso,
	input wire data_terminal_ready_pin,
	input wire dtr_clock_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire cks_wr = reg_wr && reg_addr == 4'h3;
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	samp_upper_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h2 |-> reg_rdata[7:4] == 4'h0)
		else $error("sampling upper bits not zero");
	tx_iso_on_a: assert property (cks_wr && reg_wdata[7] |-> ##[1:3] tx_iso)
		else $error("tx 1x mode not entered");
	rx_iso_off_a: assert property (cks_wr && !reg_wdata[3] |-> ##[1:3] !rx_iso)
		else $error("rx 1x mode not left");
	dtr_clock_a: assert property (cks_wr && (reg_wdata[4] || reg_wdata[5]) |-> ##[1:3] dtr_clock_out)
		else $error("clock not routed to terminal ready");
	dtr_normal_a: assert property (!dtr_clock_out && !$past(dtr_clock_out) && $past(rst_b)
		|-> data_terminal_ready_pin == $past(dtr_normal))
		else $error("terminal ready not normal level");
	tx_sample_a: assert property (!tx_iso && !$past(tx_iso) |-> tx_sample_tick == $past(nx_tick))
		else $error("tx sample tick not from nx tick");
	bit_gap_a: assert property (tx_bit_tick && !tx_iso |=> !tx_bit_tick [*3])
		else $error("bit ticks closer than four samples");
endmodule // ubg_baud_gen_sva

bind ubg_baud_gen ubg_baud_gen_sva ubg_baud_gen_sva_inst (.clk, .rst_b, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .ring_indicate_pin, .data_set_ready_pin, .dtr_normal, .nx_tick,
	.tx_sample_tick, .tx_bit_tick, .rx_sample_tick, .tx_iso, .rx_iso, .data_terminal_ready_pin,
	.dtr_clock_out);

// file: ubg_ext_clk.sv
// External 1x bit clock sources on the modem pins
`timescale 1ns/1ps
module ubg_ext_clk (
	// Control from the bench
	input wire run,
	// Clock pins into the generator
	output reg ring_indicate_pin,
	output reg data_set_ready_pin
);
	// Sources stand low outside frames; phases unrelated to the system clock
	initial begin
		ring_indicate_pin = 1'b0;
		forever #100 ring_indicate_pin = run & ~ring_indicate_pin;
	end
	initial begin
		data_set_ready_pin = 1'b0;
		#7;
		forever #125 data_set_ready_pin = run & ~data_set_ready_pin;
	end
endmodule // ubg_ext_clk

// file: testbench.sv
// Self-checking bench for the baud-rate generator
`timescale 1ns/1ps
module testbench;
	reg clk, rst_b, reg_wr, reg_rd, dtr_normal, ext_run;
	reg [3:0] reg_addr;
	reg [7:0] reg_wdata;
	wire [7:0] reg_rdata;
	wire ring_indicate_pin, data_set_ready_pin, nx_tick, tx_sample_tick, tx_bit_tick;
	wire rx_sample_tick, tx_iso, rx_iso, data_terminal_ready_pin, dtr_clock_out;
	int n_errors = 0, checks = 0, cycles = 0, n, d;
	logic [7:0] rv, v, c;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	ubg_baud_gen ubg_baud_gen_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ring_indicate_pin, .data_set_ready_pin, .dtr_normal, .nx_tick,
		.tx_sample_tick, .tx_bit_tick, .rx_sample_tick, .tx_iso, .rx_iso,
		.data_terminal_ready_pin, .dtr_clock_out);
	ubg_ext_clk ubg_ext_clk_inst (.run(ext_run), .ring_indicate_pin, .data_set_ready_pin);
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task wr(input [3:0] a, input [7:0] dat);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	function logic pick(input int w);
		case (w)
			0: pick = nx_tick;
			1: pick = tx_bit_tick;
			default: pick = rx_sample_tick;
		endcase
	endfunction
	// Cycles spanned by k tick intervals, starting from a fresh tick
	task meas(input int w, input int k, output int cnt);
		int t;
		t = 0;
		cnt = 0;
		#1;
		while (pick(w) !== 1'b1 && t < 3000) begin
			@(posedge clk);
			#1 t++;
		end
		repeat (k) begin
			@(posedge clk);
			#1 cnt++;
			while (pick(w) !== 1'b1 && cnt < 9000) begin
				@(posedge clk);
				#1 cnt++;
			end
		end
	endtask
	// Reference model: eight nx periods in cycles
	function int per8(input int dv, input int cp, input int en);
		int m;
		m = cp >> 3;
		if (m == 0) m = 1;
		return (dv == 0 ? 1 : dv) * (en != 0 ? 8 * m + (cp & 7) : 8);
	endfunction
	task finish_test();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{rst_b, reg_wr, reg_rd, ext_run} = 4'h0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		dtr_normal = 1'b1;
		void'($urandom(32'h530baf9d));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(4'h1);
		chk(rv, 8'h08, "prescale reset");
		rd(4'h2);
		chk(rv, 8'h00, "sampling reset");
		rd(4'hF);
		chk(rv, 8'h00, "unmapped read");
		meas(1, 1, n);
		chk(n, 16, "reset bit period");
		$display("test reset done");
		for (int i = 0; i < 18; i++) begin
			v = i < 16 ? {4'($urandom), 4'(i)} : 8'(i);
			dtr_normal <= 1'($urandom);
			wr(4'h2, v);
			rd(4'h2);
			chk(rv, {4'h0, v[3:0]}, "sampling readback");
			meas(1, 1, n);
			chk(n, v[3:0] < 4 ? 16 : v[3:0], "bit period");
		end
		$display("test sampling done");
		wr(4'h7, 8'h80);
		wr(4'h1, 8'h13);
		meas(0, 8, n);
		chk(n, 8, "prescaler locked");
		wr(4'h6, 8'h10);
		wr(4'h7, 8'h80);
		for (int i = 0; i < 6; i++) begin
			c = i == 0 ? 8'h03 : 8'($urandom);
			d = 1 + $urandom % 3;
			wr(4'h1, c);
			wr(4'h4, 8'(d));
			meas(0, 8, n);
			chk(n, per8(d, c, 1), "fractional period");
		end
		wr(4'h7, 8'h00);
		meas(0, 8, n);
		chk(n, per8(d, c, 0), "bypass period");
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h01);
		meas(0, 8, n);
		chk(n, 2048, "high divisor");
		wr(4'h5, 8'h00);
		wr(4'h4, 8'h01);
		$display("test divider done");
		wr(4'h2, 8'h05);
		wr(4'h3, 8'hCC);
		rd(4'h8);
		chk(rv[7:6], 2'b11, "iso status");
		chk({tx_iso, rx_iso}, 2'b11, "iso outputs");
		ext_run <= 1'b1;
		meas(1, 2, n);
		chk(n, 16, "tx 1x period");
		meas(2, 2, n);
		chk(n, 20, "rx 1x period");
		ext_run <= 1'b0;
		$display("test isochronous done");
		// Odd divisor, so pairs sampled two cycles apart see both clock phases
		wr(4'h4, 8'h03);
		for (int i = 0; i < 2; i++) begin
			wr(4'h3, i == 0 ? 8'h10 : 8'h20);
			d = 0;
			repeat (40) begin
				@(posedge clk);
				#1 v[0] = data_terminal_ready_pin;
				@(posedge clk);
				#1 d += (v[0] !== data_terminal_ready_pin);
			end
			chk(d > 0, 1, "terminal ready clock");
			chk(dtr_clock_out, 1'b1, "terminal ready clock flag");
		end
		wr(4'h3, 8'h00);
		dtr_normal <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk(data_terminal_ready_pin, 1'b0, "terminal ready normal");
		chk(dtr_clock_out, 1'b0, "terminal ready flag off");
		$display("test terminal ready done");
		finish_test();
	end
endmodule // testbench
